// *** hw/svm_pkg.sv ***
package svm_pkg;
    // ==========================================================
    // Register offsets
    localparam logic [7:0] REG_RD_2V5 = 8'h20;
    localparam logic [7:0] REG_RD_SUP = 8'h22;
    localparam logic [7:0] REG_CONFIG_ONE = 8'h40;
    localparam logic [7:0] REG_STATUS = 8'h41;
    localparam logic [7:0] REG_LO_2V5 = 8'h44;
    localparam logic [7:0] REG_HI_2V5 = 8'h45;
    localparam logic [7:0] REG_LO_SUP = 8'h48;
    localparam logic [7:0] REG_HI_SUP = 8'h49;
    // ==========================================================
    // Reset values
    localparam logic [7:0] RST_CONFIG_ONE = 8'h00;
    localparam logic [7:0] RST_LO_LIMIT = 8'h00;
    localparam logic [7:0] RST_HI_LIMIT = 8'hff;
    localparam logic [9:0] RST_READING = 10'h000;
    // ==========================================================
    // Field positions
    localparam int CFG_BUS_TIMEOUT_DISABLE = 6;
    localparam int CFG_SUPPLY_5V = 7;
    localparam int STAT_2V5 = 0;
    localparam int STAT_SUP = 1;
    // ==========================================================
    // Bus constants
    localparam logic [6:0] ALERT_RESP_ADDR = 7'h0c;
    localparam logic [6:0] DFLT_SLAVE_ADDR = 7'h2e;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    // ==========================================================
    // Timing
    localparam int CLK_HZ = 40_000_000;
    localparam int TIMEOUT_MS = 25;
    localparam int TIMEOUT_CYCLES_DFLT = TIMEOUT_MS * (CLK_HZ / 1000);
    localparam int SAMPLE_US = 711;
    localparam int SAMPLE_CYCLES_DFLT = SAMPLE_US * (CLK_HZ / 1_000_000);
    localparam int AVG_SAMPLES = 16;
    localparam logic [9:0] NOMINAL_CODE = 10'h300;
    // ==========================================================
    // Types
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_AACK,
        ST_TX,
        ST_MACK,
        ST_RX,
        ST_WACK
    } svm_state_e;
endpackage: svm_pkg

// *** hw/svm_sync.sv ***
`timescale 1ns/1ps
module svm_sync #(
    parameter logic RESET_VAL = 1'b1
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic reset_n_in,
    // Signal
    input wire logic async_in,
    output logic sync_out
);
    logic meta_ff;
    logic sync_ff;

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            meta_ff <= RESET_VAL;
            sync_ff <= RESET_VAL;
        end else begin
            meta_ff <= async_in;
            sync_ff <= meta_ff;
        end
    end

    assign sync_out = sync_ff;
endmodule: svm_sync

// *** hw/svm_meas.sv ***
`timescale 1ns/1ps
module svm_meas #(
    parameter int SAMPLE_CYCLES = svm_pkg::SAMPLE_CYCLES_DFLT,
    parameter int AVG_COUNT = svm_pkg::AVG_SAMPLES
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic reset_n_in,
    // Converter
    input wire logic [9:0] adc_code_in,
    input wire logic adc_done_in,
    output logic adc_start_out,
    output logic adc_channel_out,
    // Readings
    output logic [9:0] rd_2v5_out,
    output logic [9:0] rd_sup_out,
    output logic rd_update_out,
    output logic rd_chan_out
);
    import svm_pkg::*;
    localparam int AVG_W = $clog2(AVG_COUNT);
    localparam int ACC_W = 10 + AVG_W;
    localparam int TICK_W = $clog2(SAMPLE_CYCLES);

    if (AVG_COUNT < 2 || (1 << AVG_W) != AVG_COUNT) $error("AVG_COUNT must be a power of two");
    if (SAMPLE_CYCLES < 2) $error("SAMPLE_CYCLES too small");

    logic [TICK_W-1:0] tick_ff;
    logic busy_ff;
    logic [AVG_W-1:0] cnt_ff;
    logic [ACC_W-1:0] acc_ff;
    logic chan_ff;
    logic [ACC_W-1:0] nxt_acc;
    logic tick;
    logic last;

    assign tick = tick_ff == TICK_W'(SAMPLE_CYCLES - 1);
    assign nxt_acc = acc_ff + ACC_W'(adc_code_in);
    assign last = adc_done_in && busy_ff && cnt_ff == AVG_W'(AVG_COUNT - 1);

    // ==========================================================
    // Conversion pacing
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            tick_ff <= '0;
            busy_ff <= 1'b0;
        end else begin
            tick_ff <= tick ? '0 : tick_ff + 1'b1;
            if (tick) begin
                busy_ff <= 1'b1;
            end else if (adc_done_in) begin
                busy_ff <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Averaging and channel stepping
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            cnt_ff <= '0;
            acc_ff <= '0;
            chan_ff <= 1'b0;
            rd_2v5_out <= RST_READING;
            rd_sup_out <= RST_READING;
            rd_update_out <= 1'b0;
            rd_chan_out <= 1'b0;
        end else begin
            rd_update_out <= last;
            if (adc_done_in && busy_ff) begin
                cnt_ff <= cnt_ff + 1'b1;
                acc_ff <= last ? '0 : nxt_acc;
            end
            if (last) begin
                // Full-width sum shifted keeps all 10 result bits
                if (chan_ff) begin
                    rd_sup_out <= nxt_acc[ACC_W-1:AVG_W];
                end else begin
                    rd_2v5_out <= nxt_acc[ACC_W-1:AVG_W];
                end
                rd_chan_out <= chan_ff;
                chan_ff <= ~chan_ff;
            end
        end
    end

    assign adc_start_out = tick;
    assign adc_channel_out = chan_ff;
endmodule: svm_meas

// *** hw/svm_top.sv ***
`timescale 1ns/1ps
module svm_top #(
    parameter logic [6:0] SLAVE_ADDR = svm_pkg::DFLT_SLAVE_ADDR,
    parameter int TIMEOUT_CYCLES = svm_pkg::TIMEOUT_CYCLES_DFLT,
    parameter int SAMPLE_CYCLES = svm_pkg::SAMPLE_CYCLES_DFLT,
    parameter int AVG_COUNT = svm_pkg::AVG_SAMPLES
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic reset_n_in,
    // SMBus clock and data
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_out,
    // Alert, open drain
    input wire logic alert_in,
    output logic alert_out,
    output logic alert_oe_out,
    // Converter
    input wire logic [9:0] adc_code_in,
    input wire logic adc_done_in,
    output logic adc_start_out,
    output logic adc_channel_out,
    output logic adc_supply_5v_out
);
    import svm_pkg::*;
    localparam int TO_W = $clog2(TIMEOUT_CYCLES + 1);

    if (SLAVE_ADDR == ALERT_RESP_ADDR) $error("Slave address clashes with alert response address");
    if (TIMEOUT_CYCLES < 2) $error("TIMEOUT_CYCLES too small");

    // ==========================================================
    // Pin synchronisers
    logic scl_s;
    logic sda_s;
    logic scl_q_ff;
    logic sda_q_ff;

    svm_sync #(.RESET_VAL(1'b1)) u_scl_sync (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .async_in(scl_in),
        .sync_out(scl_s)
    );

    svm_sync #(.RESET_VAL(1'b1)) u_sda_sync (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .async_in(sda_in),
        .sync_out(sda_s)
    );

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            scl_q_ff <= 1'b1;
            sda_q_ff <= 1'b1;
        end else begin
            scl_q_ff <= scl_s;
            sda_q_ff <= sda_s;
        end
    end

    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;
    logic bus_edge;

    assign scl_rise = scl_s && !scl_q_ff;
    assign scl_fall = !scl_s && scl_q_ff;
    assign bus_start = scl_s && scl_q_ff && sda_q_ff && !sda_s;
    assign bus_stop = scl_s && scl_q_ff && !sda_q_ff && sda_s;
    assign bus_edge = (scl_s != scl_q_ff) || (sda_s != sda_q_ff);

    // ==========================================================
    // Register state
    logic [7:0] ptr_ff;
    logic [7:0] config_ff;
    logic [7:0] lo_2v5_ff;
    logic [7:0] hi_2v5_ff;
    logic [7:0] lo_sup_ff;
    logic [7:0] hi_sup_ff;
    logic [1:0] status_ff;
    logic [1:0] nxt_status;
    logic alert_ff;

    logic [9:0] rd_2v5;
    logic [9:0] rd_sup;
    logic rd_update;
    logic rd_chan;

    svm_meas #(
        .SAMPLE_CYCLES(SAMPLE_CYCLES),
        .AVG_COUNT(AVG_COUNT)
    ) u_meas (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .adc_code_in(adc_code_in),
        .adc_done_in(adc_done_in),
        .adc_start_out(adc_start_out),
        .adc_channel_out(adc_channel_out),
        .rd_2v5_out(rd_2v5),
        .rd_sup_out(rd_sup),
        .rd_update_out(rd_update),
        .rd_chan_out(rd_chan)
    );

    // Registers hold the eight upper bits of each 10-bit reading
    function automatic logic [7:0] rd_mux(input logic [7:0] addr);
        logic [7:0] val;
        val = 8'h00;
        if (addr == REG_RD_2V5) begin
            val = rd_2v5[9:2];
        end else if (addr == REG_RD_SUP) begin
            val = rd_sup[9:2];
        end else if (addr == REG_CONFIG_ONE) begin
            val = config_ff;
        end else if (addr == REG_STATUS) begin
            val = {6'h00, status_ff};
        end else if (addr == REG_LO_2V5) begin
            val = lo_2v5_ff;
        end else if (addr == REG_HI_2V5) begin
            val = hi_2v5_ff;
        end else if (addr == REG_LO_SUP) begin
            val = lo_sup_ff;
        end else if (addr == REG_HI_SUP) begin
            val = hi_sup_ff;
        end
        return val;
    endfunction: rd_mux

    // ==========================================================
    // Bus state machine
    svm_state_e state_ff;
    logic [3:0] bit_cnt_ff;
    logic [7:0] rx_sh_ff;
    logic [7:0] tx_sh_ff;
    logic drive_ff;
    logic rw_ff;
    logic ara_ff;
    logic wr_idx_ff;
    logic ack_seen_ff;
    logic timeout;

    logic byte_in;
    logic wr_ptr;
    logic wr_reg;
    logic load_tx;
    logic stat_rd;
    logic [7:0] tx_byte;
    logic addr_dev;
    logic addr_ara;

    assign byte_in = scl_fall && state_ff == ST_RX && bit_cnt_ff == BITS_PER_BYTE;
    assign wr_ptr = byte_in && !wr_idx_ff;
    assign wr_reg = byte_in && wr_idx_ff;
    assign load_tx = scl_fall && ((state_ff == ST_AACK && rw_ff) || (state_ff == ST_MACK && ack_seen_ff));
    assign stat_rd = load_tx && !ara_ff && ptr_ff == REG_STATUS;
    always_comb tx_byte = ara_ff ? {SLAVE_ADDR, 1'b0} : rd_mux(ptr_ff);
    assign addr_dev = rx_sh_ff[7:1] == SLAVE_ADDR;
    // Alert response is only answered for a read while alerting
    assign addr_ara = rx_sh_ff[7:1] == ALERT_RESP_ADDR && rx_sh_ff[0] && alert_ff;

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state_ff <= ST_IDLE;
            bit_cnt_ff <= 4'h0;
            rx_sh_ff <= 8'h00;
            tx_sh_ff <= 8'hff;
            drive_ff <= 1'b0;
            rw_ff <= 1'b0;
            ara_ff <= 1'b0;
            wr_idx_ff <= 1'b0;
            ack_seen_ff <= 1'b0;
        end else if (bus_start) begin
            // Repeated start also lands here
            state_ff <= ST_ADDR;
            bit_cnt_ff <= 4'h0;
            drive_ff <= 1'b0;
        end else if (bus_stop || timeout) begin
            state_ff <= ST_IDLE;
            drive_ff <= 1'b0;
        end else begin
            case (state_ff)
                ST_ADDR: begin
                    if (scl_rise) begin
                        rx_sh_ff <= {rx_sh_ff[6:0], sda_s};
                        bit_cnt_ff <= bit_cnt_ff + 4'h1;
                    end else if (scl_fall && bit_cnt_ff == BITS_PER_BYTE) begin
                        if (addr_dev || addr_ara) begin
                            state_ff <= ST_AACK;
                            drive_ff <= 1'b1;
                            rw_ff <= rx_sh_ff[0];
                            ara_ff <= addr_ara;
                        end else begin
                            state_ff <= ST_IDLE;
                        end
                    end
                end
                ST_AACK: begin
                    if (scl_fall) begin
                        bit_cnt_ff <= 4'h0;
                        wr_idx_ff <= 1'b0;
                        if (rw_ff) begin
                            state_ff <= ST_TX;
                            tx_sh_ff <= tx_byte;
                            drive_ff <= ~tx_byte[7];
                        end else begin
                            state_ff <= ST_RX;
                            drive_ff <= 1'b0;
                        end
                    end
                end
                ST_TX: begin
                    if (scl_rise) begin
                        bit_cnt_ff <= bit_cnt_ff + 4'h1;
                        // In an alert response, a released one read back as zero loses arbitration
                        if (ara_ff && tx_sh_ff[7] && !sda_s) begin
                            state_ff <= ST_IDLE;
                            drive_ff <= 1'b0;
                        end
                    end else if (scl_fall) begin
                        if (bit_cnt_ff == BITS_PER_BYTE) begin
                            state_ff <= ST_MACK;
                            drive_ff <= 1'b0;
                        end else begin
                            tx_sh_ff <= {tx_sh_ff[6:0], 1'b1};
                            drive_ff <= ~tx_sh_ff[6];
                        end
                    end
                end
                ST_MACK: begin
                    if (scl_rise) begin
                        ack_seen_ff <= !sda_s;
                    end else if (scl_fall) begin
                        bit_cnt_ff <= 4'h0;
                        if (ack_seen_ff) begin
                            state_ff <= ST_TX;
                            tx_sh_ff <= tx_byte;
                            drive_ff <= ~tx_byte[7];
                        end else begin
                            state_ff <= ST_IDLE;
                        end
                    end
                end
                ST_RX: begin
                    if (scl_rise) begin
                        rx_sh_ff <= {rx_sh_ff[6:0], sda_s};
                        bit_cnt_ff <= bit_cnt_ff + 4'h1;
                    end else if (byte_in) begin
                        state_ff <= ST_WACK;
                        drive_ff <= 1'b1;
                        wr_idx_ff <= 1'b1;
                    end
                end
                ST_WACK: begin
                    if (scl_fall) begin
                        state_ff <= ST_RX;
                        bit_cnt_ff <= 4'h0;
                        drive_ff <= 1'b0;
                    end
                end
                default: begin
                    drive_ff <= 1'b0;
                end
            endcase
        end
    end

    // ==========================================================
    // Lockup timeout
    logic [TO_W-1:0] to_cnt_ff;

    assign timeout = to_cnt_ff == TO_W'(TIMEOUT_CYCLES - 1);

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            to_cnt_ff <= '0;
        end else if (config_ff[CFG_BUS_TIMEOUT_DISABLE] || state_ff == ST_IDLE) begin
            to_cnt_ff <= '0;
        end else if (bus_edge || timeout) begin
            to_cnt_ff <= '0;
        end else begin
            to_cnt_ff <= to_cnt_ff + 1'b1;
        end
    end

    // ==========================================================
    // Pointer and writable registers
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ptr_ff <= 8'h00;
            config_ff <= RST_CONFIG_ONE;
            lo_2v5_ff <= RST_LO_LIMIT;
            hi_2v5_ff <= RST_HI_LIMIT;
            lo_sup_ff <= RST_LO_LIMIT;
            hi_sup_ff <= RST_HI_LIMIT;
        end else if (wr_ptr) begin
            ptr_ff <= rx_sh_ff;
        end else if (wr_reg) begin
            // Read-only and unmapped offsets ignore the data byte
            if (ptr_ff == REG_CONFIG_ONE) begin
                config_ff <= rx_sh_ff;
            end else if (ptr_ff == REG_LO_2V5) begin
                lo_2v5_ff <= rx_sh_ff;
            end else if (ptr_ff == REG_HI_2V5) begin
                hi_2v5_ff <= rx_sh_ff;
            end else if (ptr_ff == REG_LO_SUP) begin
                lo_sup_ff <= rx_sh_ff;
            end else if (ptr_ff == REG_HI_SUP) begin
                hi_sup_ff <= rx_sh_ff;
            end
        end
    end

    // ==========================================================
    // Limit check, status and alert
    logic [7:0] new_rd;
    logic viol_2v5;
    logic viol_sup;
    logic [1:0] viol_now;
    logic [1:0] viol_set;

    assign new_rd = rd_chan ? rd_sup[9:2] : rd_2v5[9:2];
    assign viol_2v5 = rd_2v5[9:2] < lo_2v5_ff || rd_2v5[9:2] > hi_2v5_ff;
    assign viol_sup = rd_sup[9:2] < lo_sup_ff || rd_sup[9:2] > hi_sup_ff;
    assign viol_now = {viol_sup, viol_2v5};
    assign viol_set[STAT_2V5] = rd_update && !rd_chan && (new_rd < lo_2v5_ff || new_rd > hi_2v5_ff);
    assign viol_set[STAT_SUP] = rd_update && rd_chan && (new_rd < lo_sup_ff || new_rd > hi_sup_ff);

    // Status read keeps a bit only while its fault persists; a new hit wins
    always_comb begin
        nxt_status = stat_rd ? viol_now : status_ff;
        nxt_status = nxt_status | viol_set;
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            status_ff <= 2'h0;
            alert_ff <= 1'b0;
        end else begin
            status_ff <= nxt_status;
            alert_ff <= |nxt_status;
        end
    end

    // ==========================================================
    // Pin drivers
    assign sda_out = 1'b0;
    assign sda_oe_out = drive_ff;
    assign alert_out = 1'b0;
    assign alert_oe_out = alert_ff;
    assign adc_supply_5v_out = config_ff[CFG_SUPPLY_5V];
endmodule: svm_top

// *** testbench/svm_top_sva.sv ***
`timescale 1ns/1ps
module svm_top_sva #(
    parameter int SAMPLE_CYCLES = 20,
    parameter int AVG_COUNT = 16
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic reset_n_in,
    // Bus
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe_out,
    input wire logic alert_in,
    input wire logic alert_out,
    input wire logic alert_oe_out,
    // Converter
    input wire logic [9:0] adc_code_in,
    input wire logic adc_done_in,
    input wire logic adc_start_out,
    input wire logic adc_channel_out,
    input wire logic adc_supply_5v_out
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!reset_n_in);
    // ==========================================================
    // Helper counters
    int gap_ff;
    int dcnt_ff;
    int since_ff;
    logic seen_ff;
    logic ch_ff;
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            gap_ff <= 0;
            seen_ff <= 1'b0;
        end else begin
            gap_ff <= adc_start_out ? 1 : gap_ff + 1;
            seen_ff <= seen_ff | adc_start_out;
        end
    end
    // Dones counted per channel dwell
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ch_ff <= 1'b0;
            dcnt_ff <= 0;
        end else begin
            ch_ff <= adc_channel_out;
            dcnt_ff <= (adc_channel_out != ch_ff) ? 0 : dcnt_ff + int'(adc_done_in);
        end
    end
    // Saturates so a stale done cannot excuse an alert
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            since_ff <= 15;
        end else begin
            since_ff <= adc_done_in ? 0 : (since_ff < 15 ? since_ff + 1 : 15);
        end
    end
    // ==========================================================
    // Assertions
    a_sda_open_drain: assert property (sda_out == 1'b0) else $error("sda driven high");
    a_alert_open_drain: assert property (alert_out == 1'b0) else $error("alert driven high");
    a_oe_scl_low: assert property ($changed(sda_oe_out) |-> $past(!scl_in, 2))
        else $error("sda changed while scl high");
    a_oe_bit_hold: assert property ($rose(sda_oe_out) |=> sda_oe_out [*3])
        else $error("sda drive too short");
    a_start_pulse: assert property (adc_start_out |=> !adc_start_out) else $error("start not a pulse");
    a_start_spacing: assert property (adc_start_out && seen_ff |-> gap_ff == SAMPLE_CYCLES)
        else $error("sample spacing wrong");
    a_chan_dwell: assert property (adc_channel_out != ch_ff |-> dcnt_ff == AVG_COUNT)
        else $error("channel switched early");
    a_alert_cause: assert property ($rose(alert_oe_out) |-> since_ff <= 4)
        else $error("alert without new reading");
    c_alert_set: cover property ($rose(alert_oe_out));
    c_alert_clr: cover property ($fell(alert_oe_out));
    c_chan_step: cover property (adc_channel_out != ch_ff);
endmodule: svm_top_sva

bind svm_top svm_top_sva #(.SAMPLE_CYCLES(SAMPLE_CYCLES), .AVG_COUNT(AVG_COUNT)) svm_top_sva_inst (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe_out(sda_oe_out), .alert_in(alert_in), .alert_out(alert_out), .alert_oe_out(alert_oe_out),
    .adc_code_in(adc_code_in), .adc_done_in(adc_done_in), .adc_start_out(adc_start_out),
    .adc_channel_out(adc_channel_out), .adc_supply_5v_out(adc_supply_5v_out)
);

// *** testbench/svm_host.sv ***
`timescale 1ns/1ps
module svm_host (
    // Clock
    input wire logic clk_in,
    // Bus, SDA pulled up
    input wire logic dev_oe_in,
    output logic scl_out,
    output logic sda_out
);
    logic sda_drv = 1'b1;
    initial scl_out = 1'b1;
    assign sda_out = sda_drv & ~dev_oe_in;
    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
    endtask: tick
    // ==========================================================
    // One bit, 8 clocks; data moves mid-low, sampled at end of high
    task automatic bit1(input logic b, output logic r);
        sda_drv <= b;
        tick(2);
        scl_out <= 1'b1;
        tick(4);
        r = sda_out;
        scl_out <= 1'b0;
        tick(2);
    endtask: bit1
    // Serves as repeated start as well
    task automatic start();
        sda_drv <= 1'b1;
        tick(2);
        scl_out <= 1'b1;
        tick(4);
        sda_drv <= 1'b0;
        tick(4);
        scl_out <= 1'b0;
        tick(2);
    endtask: start
    task automatic stop();
        sda_drv <= 1'b0;
        tick(2);
        scl_out <= 1'b1;
        tick(4);
        sda_drv <= 1'b1;
        tick(4);
    endtask: stop
    task automatic bits8(input logic [7:0] d, output logic [7:0] q);
        for (int i = 7; i >= 0; i--) begin
            bit1(d[i], q[i]);
        end
    endtask: bits8
    task automatic xfer(input logic [7:0] d, input logic ack, output logic [7:0] q, output logic a);
        bits8(d, q);
        bit1(ack, a);
    endtask: xfer
endmodule: svm_host

// *** testbench/tb_svm_top.sv ***
`timescale 1ns/1ps
module tb_svm_top;
    import svm_pkg::*;
    // ==========================================================
    // Scaled counts keep the run short
    localparam int TO_CYC = 200;
    localparam int SMP_CYC = 20;
    localparam logic [6:0] SA = DFLT_SLAVE_ADDR;
    logic clk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic adc_done = 1'b0;
    logic flip = 1'b0;
    logic [9:0] adc_code = 10'h000;
    logic scl, sda, sda_oe, alert_oe, adc_start, adc_ch, sup5v, a;
    logic [7:0] q;
    int bad_count = 0;
    int cmp_count = 0;
    svm_top #(.TIMEOUT_CYCLES(TO_CYC), .SAMPLE_CYCLES(SMP_CYC)) svm_top_inst (
        .clk_in(clk_in), .reset_n_in(reset_n_in), .scl_in(scl), .sda_in(sda), .sda_out(),
        .sda_oe_out(sda_oe), .alert_in(~alert_oe), .alert_out(), .alert_oe_out(alert_oe),
        .adc_code_in(adc_code), .adc_done_in(adc_done), .adc_start_out(adc_start),
        .adc_channel_out(adc_ch), .adc_supply_5v_out(sup5v)
    );
    svm_host svm_host_inst (.clk_in(clk_in), .dev_oe_in(sda_oe), .scl_out(scl), .sda_out(sda));
    initial begin
        forever #12.5 clk_in = ~clk_in;
    end
    // Converter: 2.5 V input alternates around 0x300, supply sits at 0x200
    always @(posedge clk_in) begin
        adc_done <= adc_start;
        flip <= flip ^ adc_start;
        adc_code <= adc_start ? (adc_ch ? 10'h200 : (flip ? 10'h2fe : 10'h302)) : 10'h0aa;
    end
    // ==========================================================
    // Access tasks
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
        cmp_count++;
        if (s !== e) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask: chk
    task automatic wr(input logic [7:0] p, input logic [7:0] d, input bit two);
        svm_host_inst.start();
        svm_host_inst.xfer({SA, 1'b0}, 1'b1, q, a);
        chk("addr_ack", 8'h00, {7'h00, a});
        svm_host_inst.xfer(p, 1'b1, q, a);
        if (two) begin
            svm_host_inst.xfer(d, 1'b1, q, a);
        end
        svm_host_inst.stop();
    endtask: wr
    task automatic rd(input logic [6:0] ad, input logic [7:0] rv, output logic [7:0] v);
        svm_host_inst.start();
        svm_host_inst.xfer({ad, 1'b1}, 1'b1, q, a);
        chk("read_ack", 8'h00, {7'h00, a});
        svm_host_inst.xfer(rv, 1'b1, v, a);
        svm_host_inst.stop();
    endtask: rd
    task automatic get(input logic [7:0] p, input logic [7:0] e, input string n);
        logic [7:0] v;
        wr(p, 8'h00, 1'b0);
        rd(SA, 8'hff, v);
        chk(n, e, v);
    endtask: get
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask: finish_test
    initial begin
        #2ms;
        bad_count++;
        finish_test();
    end
    // ==========================================================
    // Tests
    initial begin
        repeat (8) @(posedge clk_in);
        reset_n_in <= 1'b1;
        repeat (4) @(posedge clk_in);
        get(REG_RD_SUP, 8'h00, "sup_reading");
        get(REG_CONFIG_ONE, 8'h00, "config_one");
        get(REG_LO_2V5, 8'h00, "lo_2v5");
        get(REG_HI_2V5, 8'hff, "hi_2v5");
        get(REG_HI_SUP, 8'hff, "hi_sup");
        $display("test reset values done");
        wr(REG_LO_SUP, 8'h5a, 1'b1);
        get(REG_LO_SUP, 8'h5a, "lo_sup");
        get(8'h7f, 8'h00, "unmapped");
        wr(REG_CONFIG_ONE, 8'h80, 1'b1);
        chk("supply_5v", 8'h01, {7'h00, sup5v});
        get(REG_CONFIG_ONE, 8'h80, "config_one");
        wr(REG_CONFIG_ONE, 8'h00, 1'b1);
        chk("supply_3v3", 8'h00, {7'h00, sup5v});
        $display("test register access done");
        repeat (1400) @(posedge clk_in);
        get(REG_RD_2V5, 8'hc0, "rd_2v5");
        get(REG_RD_SUP, 8'h80, "rd_sup");
        chk("alert_idle", 8'h00, {7'h00, alert_oe});
        $display("test readings done");
        wr(REG_HI_2V5, 8'hbf, 1'b1);
        repeat (700) @(posedge clk_in);
        chk("alert_set", 8'h01, {7'h00, alert_oe});
        rd(ALERT_RESP_ADDR, 8'hff, q);
        chk("ara_data", {SA, 1'b0}, q);
        get(REG_STATUS, 8'h01, "status");
        chk("alert_kept", 8'h01, {7'h00, alert_oe});
        rd(ALERT_RESP_ADDR, 8'h20, q);
        chk("ara_lost", 8'h20, q);
        wr(REG_HI_2V5, 8'hff, 1'b1);
        repeat (700) @(posedge clk_in);
        wr(REG_STATUS, 8'h00, 1'b0);
        rd(SA, 8'hff, q);
        chk("alert_clr", 8'h00, {7'h00, alert_oe});
        svm_host_inst.start();
        svm_host_inst.xfer({ALERT_RESP_ADDR, 1'b1}, 1'b1, q, a);
        chk("ara_refused", 8'h01, {7'h00, a});
        svm_host_inst.stop();
        $display("test alert done");
        svm_host_inst.start();
        svm_host_inst.bits8({SA, 1'b0}, q);
        repeat (6) @(posedge clk_in);
        chk("ack_held", 8'h01, {7'h00, sda_oe});
        repeat (TO_CYC + 20) @(posedge clk_in);
        chk("timeout_free", 8'h00, {7'h00, sda_oe});
        svm_host_inst.stop();
        wr(REG_CONFIG_ONE, 8'h40, 1'b1);
        svm_host_inst.start();
        svm_host_inst.bits8({SA, 1'b0}, q);
        repeat (TO_CYC + 20) @(posedge clk_in);
        chk("timeout_off", 8'h01, {7'h00, sda_oe});
        svm_host_inst.bit1(1'b1, a);
        chk("late_ack", 8'h00, {7'h00, a});
        svm_host_inst.stop();
        $display("test timeout done");
        finish_test();
    end
endmodule: tb_svm_top
